/* core/bclcfg_pkg.sv */
package bclcfg_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] BCLCFG_SETTING_ADDR = 8'h12;
  localparam logic [7:0] BCLCFG_CHDIS_ADDR = 8'h13;
  localparam logic [7:0] BCLCFG_BSTMEAS_ADDR = 8'h14;

  // field positions in the setting register
  localparam int BCLCFG_SPREAD_BIT = 2;

  // field positions in the channel-disable register
  localparam int BCLCFG_LOCKOUT_BIT = 7;
  localparam int BCLCFG_FASTSS_BIT = 6;
  localparam int BCLCFG_PUMPOFF_BIT = 5;
  localparam int BCLCFG_UNUSED_BIT = 4;
  localparam int BCLCFG_SINK_LSB = 0;
  localparam int BCLCFG_SINKS = 4;

  // reset values
  localparam logic [7:0] BCLCFG_CHDIS_RST = 8'h00;
  localparam logic [7:0] BCLCFG_BSTMEAS_RST = 8'h00;
  localparam logic BCLCFG_SPREAD_RST = 1'b0;
  localparam logic [7:0] BCLCFG_RD_IDLE = 8'h00;

  // writable mask of the channel-disable register, bit 4 excluded
  localparam logic [7:0] BCLCFG_CHDIS_MASK = 8'hEF;

  // boost measurement scale, in microvolts
  localparam int BCLCFG_BST_FULL_UV = 1300000;
  localparam int BCLCFG_BST_LSB_UV = 5100;

  // one register-port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bclcfg_req_t;

  // control levels driven to the analog blocks
  typedef struct packed {
    logic lockout_level_select;
    logic fast_soft_start;
    logic gate_pump_off;
    logic spread_amount_select;
    logic [BCLCFG_SINKS-1:0] sink_off;
  } bclcfg_ctrl_t;

endpackage

/* core/bclcfg_regs.sv */
// Functional notes
// - spread bit 0 gives six percent spread, 1 gives three percent, when active
// - channel-disable bit 7 set selects the lower input lockout threshold
// - channel-disable bit 6 set selects fast boost soft-start, clear slow
// - channel-disable bit 5 set turns off the gate-drive charge pump
// - changing pump-off bit while operating latches the device off
// - channel-disable bits 3..0 each keep one led sink output off
// - boost monitor register reports 8-bit measured code, reset zero, read only
`timescale 1ns/100ps
`default_nettype none

module bclcfg_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port from the serial bus slave
  input wire bclcfg_pkg::bclcfg_req_t req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // device state from the same clock domain
  input wire logic running_i,
  input wire logic spread_on_i,
  input wire logic meas_done_i,
  input wire logic [7:0] meas_code_i,
  // control levels to the analog side
  output bclcfg_pkg::bclcfg_ctrl_t ctrl_o,
  output logic spread_narrow_o,
  output logic latch_off_o
);
  import bclcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode shared by write and read paths

  // true when an access offset names the given register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // true for a write strobe aimed at the given register
  function automatic logic wr_hit(input bclcfg_req_t q, input logic [7:0] r);
    wr_hit = q.wr && hit(q.addr, r);
  endfunction

  // true for a read strobe aimed at the given register
  function automatic logic rd_hit(input bclcfg_req_t q, input logic [7:0] r);
    rd_hit = q.rd && hit(q.addr, r);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // channel-disable and setting registers

  logic [7:0] chdis_reg, chdis_next;
  logic spread_reg, spread_next;
  logic [7:0] wr_chdis;

  // next values of the configuration registers
  always_comb begin
    // bit 4 has no storage behind it, so it is masked on the way in
    wr_chdis = req_i.wdata & BCLCFG_CHDIS_MASK;
    chdis_next = chdis_reg;
    spread_next = spread_reg;
    // the pump-off bit is stored even when it trips the latch-off;
    // software can read back what it wrote after a latch event
    if (wr_hit(req_i, BCLCFG_CHDIS_ADDR)) begin
      chdis_next = wr_chdis;
    end
    // only the spread-amount bit of the setting register lives here;
    // the other setting fields belong to neighbouring logic
    if (wr_hit(req_i, BCLCFG_SETTING_ADDR)) begin
      spread_next = req_i.wdata[BCLCFG_SPREAD_BIT];
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chdis_reg <= BCLCFG_CHDIS_RST;
      spread_reg <= BCLCFG_SPREAD_RST;
    end else begin
      chdis_reg <= chdis_next;
      spread_reg <= spread_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch-off on a pump-off change while the device runs

  logic latch_reg, latch_next;
  logic pump_change;

  // a running converter cannot follow a charge-pump switch-over safely,
  // so the flag is sticky and only reset clears it; a write that keeps
  // the pump-off bit unchanged never trips it
  always_comb begin
    pump_change = wr_chdis[BCLCFG_PUMPOFF_BIT] ^
      chdis_reg[BCLCFG_PUMPOFF_BIT];
    latch_next = latch_reg;
    if (wr_hit(req_i, BCLCFG_CHDIS_ADDR) && running_i && pump_change) begin
      latch_next = 1'b1;
    end
  end

  // latch-off flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // narrow-spread level for the oscillator

  logic narrow_reg, narrow_next;

  // the amount bit only matters while spreading runs; outside that the
  // oscillator sees a quiet low level
  always_comb begin
    narrow_next = spread_on_i & spread_reg;
  end

  // narrow-spread flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      narrow_reg <= 1'b0;
    end else begin
      narrow_reg <= narrow_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boost monitor measurement register

  logic [7:0] bst_reg, bst_next;

  // only a finished measurement loads the monitor register; bus writes
  // to its offset are not decoded here at all
  always_comb begin
    bst_next = bst_reg;
    if (meas_done_i) begin
      bst_next = meas_code_i;
    end
  end

  // measurement register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bst_reg <= BCLCFG_BSTMEAS_RST;
    end else begin
      bst_reg <= bst_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] rdat_reg, rdat_next;
  logic rval_reg, rval_next;

  // read data is registered, so a read in the same cycle as a write
  // returns the old contents; unmapped offsets answer with zero
  always_comb begin
    rdat_next = BCLCFG_RD_IDLE;
    rval_next = req_i.rd;
    if (rd_hit(req_i, BCLCFG_CHDIS_ADDR)) begin
      rdat_next = chdis_reg;
    end else if (rd_hit(req_i, BCLCFG_BSTMEAS_ADDR)) begin
      rdat_next = bst_reg;
    end else if (rd_hit(req_i, BCLCFG_SETTING_ADDR)) begin
      rdat_next[BCLCFG_SPREAD_BIT] = spread_reg;
    end
  end

  // read data and valid flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= BCLCFG_RD_IDLE;
      rval_reg <= 1'b0;
    end else begin
      rdat_reg <= rdat_next;
      rval_reg <= rval_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  // analog control levels
  assign ctrl_o.lockout_level_select = chdis_reg[BCLCFG_LOCKOUT_BIT];
  assign ctrl_o.fast_soft_start = chdis_reg[BCLCFG_FASTSS_BIT];
  assign ctrl_o.gate_pump_off = chdis_reg[BCLCFG_PUMPOFF_BIT];
  assign ctrl_o.spread_amount_select = spread_reg;

  // one disable level per led sink, bit 0 for the first sink; a sink
  // disabled after the global enable is set is not guaranteed to follow
  genvar gi;
  generate
    for (gi = 0; gi < BCLCFG_SINKS; gi++) begin : g_sink
      assign ctrl_o.sink_off[gi] = chdis_reg[BCLCFG_SINK_LSB + gi];
    end
  endgenerate

  // status and read-back outputs
  assign spread_narrow_o = narrow_reg;
  assign latch_off_o = latch_reg;
  assign rd_data_o = rdat_reg;
  assign rd_valid_o = rval_reg;

endmodule

`default_nettype wire

/* sim/bclcfg_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module bclcfg_asserts (
  // watched design ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire bclcfg_pkg::bclcfg_req_t req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic running_i,
  input wire logic spread_on_i,
  input wire logic meas_done_i,
  input wire logic [7:0] meas_code_i,
  input wire bclcfg_pkg::bclcfg_ctrl_t ctrl_o,
  input wire logic spread_narrow_o,
  input wire logic latch_off_o
);
  import bclcfg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire cw = req_i.wr && req_i.addr == BCLCFG_CHDIS_ADDR;
  AST_UVSEL: assert property (cw |=>
    ctrl_o[7] == $past(req_i.wdata[7])) else $error("lockout bit wrong");
  AST_FASTSS: assert property (cw |=>
    ctrl_o[6] == $past(req_i.wdata[6])) else $error("soft-start bit wrong");
  AST_PUMP: assert property (cw |=>
    ctrl_o[5] == $past(req_i.wdata[5])) else $error("pump bit wrong");
  AST_SINKS: assert property (cw |=>
    ctrl_o[3:0] == $past(req_i.wdata[3:0])) else $error("sink bits wrong");
  AST_BIT4: assert property (req_i.rd && req_i.addr == BCLCFG_CHDIS_ADDR |=>
    rd_valid_o && !rd_data_o[4]) else $error("unused bit not zero");
  AST_SPREAD: assert property ($past(spread_on_i) |->
    spread_narrow_o == $past(ctrl_o[4])) else $error("spread level wrong");
  AST_LATCH: assert property (cw && running_i && req_i.wdata[5] != ctrl_o[5]
    |=> latch_off_o [*3]) else $error("latch-off missing");
  AST_MEAS: assert property (meas_done_i ##1 !meas_done_i ##1
    (req_i.rd && req_i.addr == BCLCFG_BSTMEAS_ADDR && !meas_done_i) |=>
    rd_data_o == $past(meas_code_i, 3)) else $error("measure read wrong");
  cover property (latch_off_o);
  cover property (spread_narrow_o);
  cover property (rd_valid_o && rd_data_o != 8'h00);
endmodule
bind bclcfg_regs bclcfg_asserts u_asserts (.*);
`default_nettype wire

/* sim/bclcfg_regs_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module bclcfg_regs_tb_top;
  import bclcfg_pkg::*;
  logic clk_i = 0, rst_i = 1, running_i = 0, spread_on_i = 0, meas_done_i = 0;
  logic [7:0] meas_code_i = 8'h00, rd_data_o, r;
  logic rd_valid_o, spread_narrow_o, latch_off_o;
  bclcfg_req_t req_i = '0;
  bclcfg_ctrl_t ctrl_o;
  logic [31:0] s = 32'h0AFD;
  logic [7:0] q[$];
  int fails = 0, checked = 0;
  always #12.5 clk_i = ~clk_i;
  bclcfg_regs DUT (.*);
  function automatic logic [7:0] rnd();
    s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s[7:0];
  endfunction
  task automatic cmp(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one register access, optionally with a measurement pulse
  task automatic acc(input logic w, m, input logic [7:0] a, d);
    @(posedge clk_i) req_i <= '{w, !w, a, d};
    meas_done_i <= m;
    meas_code_i <= ~d;
    @(posedge clk_i) req_i <= '0;
    meas_done_i <= 0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    q.push_back(e);
    acc(0, 0, a, 8'h00);
  endtask
  // each read answer is matched with the oldest expected value
  always @(posedge clk_i) begin
    if (rd_valid_o === 1'b1)
      cmp(rd_data_o, q.size() ? q.pop_front() : 8'hXX);
  end
  task end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    spread_on_i <= 1;
    rd(BCLCFG_CHDIS_ADDR, BCLCFG_CHDIS_RST);
    rd(BCLCFG_BSTMEAS_ADDR, BCLCFG_BSTMEAS_RST);
    repeat (8) begin
      r = rnd();
      acc(1, 0, BCLCFG_CHDIS_ADDR, r);
      acc(1, 0, BCLCFG_SETTING_ADDR, r);
      cmp(ctrl_o, {r[7:5], r[2], r[3:0]});
      rd(BCLCFG_SETTING_ADDR, r & 8'h04);
      cmp(spread_narrow_o, {7'h00, r[2]});
      rd(BCLCFG_CHDIS_ADDR, r & 8'hEF);
    end
    acc(1, 1, BCLCFG_BSTMEAS_ADDR, r);
    rd(BCLCFG_BSTMEAS_ADDR, ~r);
    rd(8'h20, 8'h00);
    acc(1, 0, BCLCFG_CHDIS_ADDR, r | 8'h20);
    cmp(latch_off_o, 8'h00);
    running_i <= 1;
    acc(1, 0, BCLCFG_CHDIS_ADDR, r & 8'hDF);
    acc(1, 0, BCLCFG_CHDIS_ADDR, r | 8'h20);
    cmp(latch_off_o, 8'h01);
    rd(BCLCFG_CHDIS_ADDR, (r | 8'h20) & 8'hEF);
    repeat (3) @(posedge clk_i);
    if (q.size() != 0) fails++;
    end_sim();
  end
endmodule
`default_nettype wire
